// ### src/port_function_select.v
// port alternate function select with axi4-lite register access
// ****************************************************************
// ****************************************************************
`timescale 1ns/10ps
`include "pin_mux_defines.vh"
module port_function_select
(
  // clock and reset
  input  wire                   aclk,
  input  wire                   aresetn,
  // axi4-lite write address
  input  wire [`AXI_ADDR_W-1:0] awaddr,
  input  wire                   awvalid,
  output reg                    awready,
  // axi4-lite write data
  input  wire [31:0]            wdata,
  input  wire [3:0]             wstrb,
  input  wire                   wvalid,
  output reg                    wready,
  // axi4-lite write response
  output reg  [1:0]             bresp,
  output reg                    bvalid,
  input  wire                   bready,
  // axi4-lite read address
  input  wire [`AXI_ADDR_W-1:0] araddr,
  input  wire                   arvalid,
  output reg                    arready,
  // axi4-lite read data
  output reg  [31:0]            rdata,
  output reg  [1:0]             rresp,
  output reg                    rvalid,
  input  wire                   rready,
  // port 1 pins
  input  wire [7:0]             port1_pin_in,
  output reg  [7:0]             port1_pin_out,
  output reg  [7:0]             port1_pin_oe_n,
  // port 3 pins
  input  wire [7:0]             port3_pin_in,
  output reg  [7:0]             port3_pin_out,
  output reg  [7:0]             port3_pin_oe_n,
  // port 4 pins
  input  wire [7:0]             port4_pin_in,
  output reg  [7:0]             port4_pin_out,
  output reg  [7:0]             port4_pin_oe_n,
  // unit configuration enables
  input  wire                   timer2_en,
  input  wire                   uart2_en,
  input  wire                   uart_en,
  input  wire                   ext_int_en,
  input  wire                   timer_en,
  // peripheral output levels per pin
  input  wire [7:0]             port1_periph_out,
  input  wire [7:0]             port3_periph_out,
  input  wire [7:0]             port4_periph_out,
  // pin levels handed to peripherals
  output reg  [7:0]             port1_periph_in,
  output reg  [7:0]             port3_periph_in,
  output reg  [7:0]             port4_periph_in,
  // adc analog channel stand-ins
  output reg                    adc_channel_0_input,
  output reg                    adc_channel_1_input,
  output reg                    adc_channel_2_input,
  output reg                    adc_channel_3_input
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  reg  [7:0]             port1_function_select; // port 1 selectors
  reg  [7:0]             port3_function_select; // port 3 selectors
  reg  [7:0]             port4_function_select; // port 4 selectors
  reg  [7:0]             port1_latch;           // port 1 data latch
  reg  [7:0]             port3_latch;           // port 3 data latch
  reg  [7:0]             port4_latch;           // port 4 data latch
  reg  [7:0]             port1_pins;            // sampled port 1 levels
  reg  [7:0]             port3_pins;            // sampled port 3 levels
  reg  [7:0]             port4_pins;            // sampled port 4 levels

  // ****************************************************************
  // bus state
  // ****************************************************************
  reg                    aw_held;  // write address captured
  reg                    w_held;   // write data captured
  reg  [`AXI_ADDR_W-1:0] aw_addr;  // captured write address
  reg  [31:0]            w_data;   // captured write data
  reg  [3:0]             w_strb;   // captured byte enables
  wire                   do_write; // commit the held write
  wire [7:0]             w_idx;    // word index of the write
  wire                   w_in_map; // write address in low window
  wire                   w_lane0;  // low byte lane enabled
  wire [7:0]             r_idx;    // word index of the read
  wire                   r_in_map; // read address in low window
  reg  [7:0]             r_byte;   // read mux result
  reg                    r_hit;    // read address mapped
  reg                    w_hit;    // write address writable

  // ****************************************************************
  // routing wires
  // ****************************************************************
  wire [23:0]            role_sel;     // effective role per pin
  wire [23:0]            input_only;   // roles that never drive
  wire [23:0]            latch_all;    // data latches joined
  wire [23:0]            periph_all;   // peripheral outputs joined
  wire [23:0]            pin_all;      // pin levels joined
  wire [23:0]            drive_low;    // pull-low decision per pin
  wire [23:0]            periph_in_all;// levels toward peripherals

  // ****************************************************************
  // effective role select per pin
  // ****************************************************************
  // port 1: unit enables on 0-3, selector bits on 4-7
  assign role_sel[1:0]   = {2{timer2_en}};
  assign role_sel[3:2]   = {2{uart2_en}};
  assign role_sel[7:4]   = port1_function_select[7:4];
  // port 3: unit enables on 0-5, i2c selectors on 6-7
  assign role_sel[9:8]   = {2{uart_en}};
  assign role_sel[11:10] = {2{ext_int_en}};
  assign role_sel[13:12] = {2{timer_en}};
  assign role_sel[15:14] = port3_function_select[7:6];
  // port 4: every bit is a selector (pwm, vsync, ddc)
  assign role_sel[23:16] = port4_function_select;

  // adc, interrupt and timer input roles only listen
  assign input_only = {`PORT4_INPUT_ONLY, `PORT3_INPUT_ONLY, `PORT1_INPUT_ONLY};

  // joined vectors for the pin cells
  assign latch_all  = {port4_latch, port3_latch, port1_latch};
  assign periph_all = {port4_periph_out, port3_periph_out, port1_periph_out};
  assign pin_all    = {port4_pin_in, port3_pin_in, port1_pin_in};

  // ****************************************************************
  // one routing cell per pin
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi = gi + 1)
    begin : g_pin
      port_pin_route u_route
      (
        .role_sel        (role_sel[gi]),
        .role_input_only (input_only[gi]),
        .gpio_latch      (latch_all[gi]),
        .periph_out      (periph_all[gi]),
        .pin_level       (pin_all[gi]),
        .drive_low       (drive_low[gi]),
        .periph_in       (periph_in_all[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // pin and peripheral outputs, registered
  // ****************************************************************
  // pins are released during reset; released means pulled high
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port1_pin_out       <= 8'h00;
      port3_pin_out       <= 8'h00;
      port4_pin_out       <= 8'h00;
      port1_pin_oe_n      <= 8'hFF;
      port3_pin_oe_n      <= 8'hFF;
      port4_pin_oe_n      <= 8'hFF;
      port1_periph_in     <= 8'hFF;
      port3_periph_in     <= 8'hFF;
      port4_periph_in     <= 8'hFF;
      adc_channel_0_input <= 1'b0;
      adc_channel_1_input <= 1'b0;
      adc_channel_2_input <= 1'b0;
      adc_channel_3_input <= 1'b0;
      port1_pins          <= 8'h00;
      port3_pins          <= 8'h00;
      port4_pins          <= 8'h00;
    end
    else
    begin
      // open-drain drive: the pin is only ever pulled low
      port1_pin_out       <= 8'h00;
      port3_pin_out       <= 8'h00;
      port4_pin_out       <= 8'h00;
      port1_pin_oe_n      <= ~drive_low[7:0];
      port3_pin_oe_n      <= ~drive_low[15:8];
      port4_pin_oe_n      <= ~drive_low[23:16];
      // levels toward peripherals, idle high outside the role
      port1_periph_in     <= periph_in_all[7:0];
      port3_periph_in     <= periph_in_all[15:8];
      port4_periph_in     <= periph_in_all[23:16];
      // adc channels see the pin only while selected
      adc_channel_0_input <= port1_function_select[4] & port1_pin_in[4];
      adc_channel_1_input <= port1_function_select[5] & port1_pin_in[5];
      adc_channel_2_input <= port1_function_select[6] & port1_pin_in[6];
      adc_channel_3_input <= port1_function_select[7] & port1_pin_in[7];
      // pin read path for software
      port1_pins          <= port1_pin_in;
      port3_pins          <= port3_pin_in;
      port4_pins          <= port4_pin_in;
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  assign w_idx    = aw_addr[9:2];
  assign w_in_map = (aw_addr[11:10] == 2'h0);
  assign w_lane0  = w_strb[0];
  assign do_write = aw_held & w_held & ~bvalid;
  assign r_idx    = araddr[9:2];
  assign r_in_map = (araddr[11:10] == 2'h0);

  // writable registers; ports 0 and 2 have no latch here
  always @*
  begin
    w_hit = 1'b0;
    if (w_in_map)
    begin
      case (w_idx)
        `PORT1_FSEL_IDX,
        `PORT3_FSEL_IDX,
        `PORT4_FSEL_IDX,
        `PORT1_LATCH_IDX,
        `PORT3_LATCH_IDX,
        `PORT4_LATCH_IDX : w_hit = 1'b1;
        default          : w_hit = 1'b0;
      endcase
    end
  end

  // read mux; reserved select bits come back as zero
  always @*
  begin
    r_byte = 8'h00;
    r_hit  = 1'b0;
    if (r_in_map)
    begin
      r_hit = 1'b1;
      case (r_idx)
        `PORT1_FSEL_IDX  : r_byte = port1_function_select;
        `PORT3_FSEL_IDX  : r_byte = port3_function_select;
        `PORT4_FSEL_IDX  : r_byte = port4_function_select;
        `PORT1_LATCH_IDX : r_byte = port1_latch;
        `PORT3_LATCH_IDX : r_byte = port3_latch;
        `PORT4_LATCH_IDX : r_byte = port4_latch;
        `PORT1_PINS_IDX  : r_byte = port1_pins;
        `PORT3_PINS_IDX  : r_byte = port3_pins;
        `PORT4_PINS_IDX  : r_byte = port4_pins;
        default          : r_hit  = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // write channels: address and data in either order
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= {`AXI_ADDR_W{1'b0}};
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `AXI_RESP_OKAY;
    end
    else
    begin
      // capture address, then refuse until the response is taken
      if (awready && awvalid)
      begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      else if (!aw_held && !bvalid)
        awready <= 1'b1;
      // capture data the same way
      if (wready && wvalid)
      begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end
      else if (!w_held && !bvalid)
        wready <= 1'b1;
      // both halves present: commit and answer
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= w_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  // reset puts every selector pin back to plain i/o; pins owned by unit enables follow their enables
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port1_function_select <= `FSEL_RESET;
      port3_function_select <= `FSEL_RESET;
      port4_function_select <= `FSEL_RESET;
      port1_latch           <= `LATCH_RESET;
      port3_latch           <= `LATCH_RESET;
      port4_latch           <= `LATCH_RESET;
    end
    else if (do_write && w_in_map && w_lane0)
    begin
      case (w_idx)
        `PORT1_FSEL_IDX  : port1_function_select <= w_data[7:0] & `PORT1_FSEL_MASK;
        `PORT3_FSEL_IDX  : port3_function_select <= w_data[7:0] & `PORT3_FSEL_MASK;
        `PORT4_FSEL_IDX  : port4_function_select <= w_data[7:0] & `PORT4_FSEL_MASK;
        `PORT1_LATCH_IDX : port1_latch           <= w_data[7:0];
        `PORT3_LATCH_IDX : port3_latch           <= w_data[7:0];
        `PORT4_LATCH_IDX : port4_latch           <= w_data[7:0];
        default          : port1_latch           <= port1_latch;
      endcase
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `AXI_RESP_OKAY;
    end
    else if (arready && arvalid)
    begin
      // answer one cycle after the address is taken
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h000000, r_byte};
      rresp   <= r_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end
    else if (rvalid)
    begin
      // hold data until the master takes it
      if (rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
    else
      arready <= 1'b1;
  end

endmodule // port_function_select

// ### src/pin_mux_defines.vh
// constants shared by the port function select design
`ifndef PIN_MUX_DEFINES_VH
`define PIN_MUX_DEFINES_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PORT1_FSEL_IDX      8'h91
`define PORT3_FSEL_IDX      8'h93
`define PORT4_FSEL_IDX      8'h94
`define PORT1_LATCH_IDX     8'h90
`define PORT3_LATCH_IDX     8'hB0
`define PORT4_LATCH_IDX     8'hC0
`define PORT1_PINS_IDX      8'hA1
`define PORT3_PINS_IDX      8'hB1
`define PORT4_PINS_IDX      8'hC1

// ****************************************************************
// field layouts and reset values
// ****************************************************************
`define PORT1_FSEL_MASK     8'hF0
`define PORT3_FSEL_MASK     8'hC0
`define PORT4_FSEL_MASK     8'hFF
`define FSEL_RESET          8'h00
`define LATCH_RESET         8'hFF
`define PORT1_INPUT_ONLY    8'hF0
`define PORT3_INPUT_ONLY    8'h3C
`define PORT4_INPUT_ONLY    8'h00

// ****************************************************************
// bus constants
// ****************************************************************
`define AXI_ADDR_W          12
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// ### src/port_pin_route.v
// one pin of the function select: picks plain i/o or the peripheral role
`timescale 1ns/10ps
module port_pin_route
(
  // selection
  input  wire role_sel,        // peripheral role active
  input  wire role_input_only, // role only listens to the pin
  // data sources
  input  wire gpio_latch,      // port data latch bit
  input  wire periph_out,      // level the peripheral wants on the pin
  input  wire pin_level,       // pin level straight from the pad, not registered
  // results
  output wire drive_low,       // pull the pin low
  output wire periph_in        // level handed to the peripheral
);

  // ****************************************************************
  // drive: latch alone in plain mode, peripheral only in its role
  // ****************************************************************
  assign drive_low = role_sel ? (~role_input_only & ~periph_out)
                              : ~gpio_latch;

  // peripheral sees idle high unless its role owns the pin
  assign periph_in = role_sel ? pin_level : 1'b1;

endmodule // port_pin_route

// ### sim/pin_pads.sv
// open-drain pin pads with pull-ups and external pull-down sources
`timescale 1ns/10ps
module pin_pads
(
  // from the block
  input  wire logic [7:0] oe_n,     // low while the block pulls the pin
  input  wire logic [7:0] pin_out,  // level driven while enabled
  // from the board
  input  wire logic [7:0] ext_low,  // outside device pulls the pin low
  // resolved wire
  output wire logic [7:0] level     // level seen on the pin
);
  // pull-up wins only where nobody pulls low
  assign level = (~oe_n & pin_out) | (oe_n & ~ext_low);
endmodule // pin_pads

// ### sim/port_function_select_properties.sv
// timing checks on the port function select pins and bus
`timescale 1ns/10ps
module port_function_select_properties
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // unit enables
  input wire logic        timer2_en,
  input wire logic        uart2_en,
  input wire logic        uart_en,
  input wire logic        ext_int_en,
  input wire logic        timer_en,
  // pins and peripherals
  input wire logic [7:0]  port1_periph_out,
  input wire logic [7:0]  port3_periph_out,
  input wire logic [7:0]  port1_pin_in,
  input wire logic [7:0]  port3_pin_in,
  input wire logic [7:0]  port1_pin_oe_n,
  input wire logic [7:0]  port3_pin_oe_n,
  input wire logic [7:0]  port4_pin_oe_n,
  input wire logic [7:0]  port1_pin_out,
  input wire logic [7:0]  port3_pin_out,
  input wire logic [7:0]  port4_pin_out,
  input wire logic [7:0]  port1_periph_in,
  input wire logic [7:0]  port3_periph_in,
  // bus answers
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        bvalid,
  input wire logic [1:0]  bresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ********
  // pin routing and read data width
  // ********
  property p_reset_gpio;
    !$past(aresetn) |-> (port1_pin_oe_n & port3_pin_oe_n & port4_pin_oe_n) == 8'hFF;
  endproperty
  a_reset_gpio: assert property (p_reset_gpio) else $error("pins not released after reset");
  property p_timer2_out;
    timer2_en |=> port1_pin_oe_n[1:0] == $past(port1_periph_out[1:0]);
  endproperty
  a_timer2_out: assert property (p_timer2_out) else $error("timer2 pins not driven");
  property p_timer2_in;
    timer2_en ##1 1'b1 |-> port1_periph_in[1:0] == $past(port1_pin_in[1:0]);
  endproperty
  a_timer2_in: assert property (p_timer2_in) else $error("timer2 pin level not passed");
  property p_uart2_out;
    uart2_en |=> port1_pin_oe_n[3:2] == $past(port1_periph_out[3:2]);
  endproperty
  a_uart2_out: assert property (p_uart2_out) else $error("uart2 pins not driven");
  property p_uart_out;
    uart_en |=> port3_pin_oe_n[1:0] == $past(port3_periph_out[1:0]);
  endproperty
  a_uart_out: assert property (p_uart_out) else $error("uart pins not driven");
  property p_int_in;
    ext_int_en |=> port3_pin_oe_n[3:2] == 2'h3 && port3_periph_in[3:2] == $past(port3_pin_in[3:2]);
  endproperty
  a_int_in: assert property (p_int_in) else $error("interrupt pins wrong");
  property p_timer_in;
    timer_en [*2] |-> port3_pin_oe_n[5:4] == 2'h3;
  endproperty
  a_timer_in: assert property (p_timer_in) else $error("timer pins not released");
  property p_unused_ignored;
    !uart_en |=> port3_periph_in[1:0] == 2'h3;
  endproperty
  a_unused_ignored: assert property (p_unused_ignored) else $error("idle role sees pin");
  property p_open_drain;
    (port1_pin_out | port3_pin_out | port4_pin_out) == 8'h00;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_read_width;
    rvalid |-> rdata[31:8] == 24'h000000;
  endproperty
  a_read_width: assert property (p_read_width) else $error("read data above byte");
  // main scenarios
  c_both_units: cover property (timer2_en && uart2_en);
  c_bad_read: cover property (rvalid && rresp == 2'h2);
  c_good_write: cover property (bvalid && bresp == 2'h0);
endmodule // port_function_select_properties

bind port_function_select port_function_select_properties u_props (.*);

// ### sim/port_function_select_tb.sv
// self-checking bench for the port function select
`timescale 1ns/10ps
module port_function_select_tb;
  // ********
  // signals
  // ********
  logic        aclk = 0, aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [7:0]  pout [0:2] = '{default: 8'hFF};  // peripheral levels
  logic [7:0]  extl [0:2] = '{default: 8'h00};  // board pull-downs
  logic [4:0]  ens = 0;                          // unit enables
  logic [3:0]  wstrb = 4'hF;                     // write byte enables
  wire  [7:0]  oen [0:2], pdo [0:2], pin [0:2], pin_per [0:2];
  wire  [3:0]  adc;
  logic [7:0]  sel [0:2], lat [0:2];             // model registers
  int          n_fail = 0, cmp_count = 0, cyc = 0, seed, i;
  localparam logic [11:0] SEL_A [0:2] = '{12'h244, 12'h24C, 12'h250};
  localparam logic [11:0] LAT_A [0:2] = '{12'h240, 12'h2C0, 12'h300};
  localparam logic [11:0] PIN_A [0:2] = '{12'h284, 12'h2C4, 12'h304};
  localparam logic [7:0]  MASK  [0:2] = '{8'hF0, 8'hC0, 8'hFF};
  always #5 aclk = ~aclk;
  port_function_select dut
  (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .port1_pin_in(pin[0]), .port1_pin_out(pdo[0]), .port1_pin_oe_n(oen[0]),
    .port3_pin_in(pin[1]), .port3_pin_out(pdo[1]), .port3_pin_oe_n(oen[1]),
    .port4_pin_in(pin[2]), .port4_pin_out(pdo[2]), .port4_pin_oe_n(oen[2]),
    .timer2_en(ens[0]), .uart2_en(ens[1]), .uart_en(ens[2]), .ext_int_en(ens[3]), .timer_en(ens[4]),
    .port1_periph_out(pout[0]), .port3_periph_out(pout[1]), .port4_periph_out(pout[2]),
    .port1_periph_in(pin_per[0]), .port3_periph_in(pin_per[1]), .port4_periph_in(pin_per[2]),
    .adc_channel_0_input(adc[0]), .adc_channel_1_input(adc[1]),
    .adc_channel_2_input(adc[2]), .adc_channel_3_input(adc[3])
  );
  // one pad row per port
  for (genvar g = 0; g < 3; g++)
  begin : g_pad
    pin_pads u_pad (.oe_n(oen[g]), .pin_out(pdo[g]), .ext_low(extl[g]), .level(pin[g]));
  end
  // ********
  // checking and bus tasks
  // ********
  task final_report;
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // write one byte register, address and data offered together
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_ok)
      begin
        aw_ok = 1;
        awvalid <= 0;
      end
      if (wready === 1'b1 && !w_ok)
      begin
        w_ok = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk(bresp, er);
  endtask
  // read one register and compare data and response
  task rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, exp);
    chk(rresp, er);
  endtask
  // ********
  // reference model of the routing
  // ********
  function logic role(int p, int b);
    if (p == 0)
      return b < 2 ? ens[0] : (b < 4 ? ens[1] : sel[0][b]);
    if (p == 1)
      return b < 2 ? ens[2] : (b < 4 ? ens[3] : (b < 6 ? ens[4] : sel[1][b]));
    return sel[2][b];
  endfunction
  function logic [7:0] exp_oe(int p);
    logic [7:0] e;
    for (int b = 0; b < 8; b++)
      e[b] = role(p, b) ? (((p == 0 && b > 3) || (p == 1 && b > 1 && b < 6)) | pout[p][b]) : lat[p][b];
    return e;
  endfunction
  task chk_pins;
    logic [7:0] lv, ei;
    for (int p = 0; p < 3; p++)
    begin
      lv = exp_oe(p) & ~extl[p];
      for (int b = 0; b < 8; b++)
        ei[b] = role(p, b) ? lv[b] : 1'b1;
      chk(oen[p], exp_oe(p));
      chk(pdo[p], 8'h00);
      chk(pin_per[p], ei);
      if (p == 0)
        chk(adc, sel[0][7:4] & lv[7:4]);
    end
  endtask
  task settle;
    repeat (3) @(posedge aclk);
  endtask
  // cycle ceiling against hangs
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report;
    end
  end
  // ********
  // main sequence
  // ********
  initial
  begin
    seed = $urandom(27229);
    for (i = 0; i < 3; i++)
    begin
      sel[i] = 8'h00;
      lat[i] = 8'hFF;
    end
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    chk_pins;
    for (i = 0; i < 3; i++)
      rd(SEL_A[i], 32'h0, 2'h0);
    // every select bit set, reserved ones must drop
    for (i = 0; i < 3; i++)
    begin
      wr(SEL_A[i], 8'hFF, 2'h0);
      sel[i] = MASK[i];
      rd(SEL_A[i], {24'h0, MASK[i]}, 2'h0);
    end
    // disabled low lane: accepted, select left as it was
    wstrb <= 4'h0;
    wr(SEL_A[0], 8'h00, 2'h0);
    wstrb <= 4'hF;
    rd(SEL_A[0], {24'h0, MASK[0]}, 2'h0);
    settle;
    chk_pins;
    rd(12'h800, 32'h0, 2'h2);
    wr(PIN_A[0], 8'h00, 2'h2);
    rd(PIN_A[1], {24'h0, exp_oe(1) & ~extl[1]}, 2'h0);
    // random selects, latches, enables and pin loads
    repeat (40)
    begin
      i = $urandom_range(2, 0);
      sel[i] = 8'($urandom);
      wr(SEL_A[i], sel[i], 2'h0);
      sel[i] = sel[i] & MASK[i];
      lat[i] = 8'($urandom);
      wr(LAT_A[i], lat[i], 2'h0);
      ens <= 5'($urandom);
      pout[i] <= 8'($urandom);
      extl[i] <= 8'($urandom);
      settle;
      chk_pins;
    end
    // reset in mid-run returns the selector pins to plain i/o; pins owned by unit enables keep their roles
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (i = 0; i < 3; i++)
    begin
      sel[i] = 8'h00;
      lat[i] = 8'hFF;
    end
    // pins need one edge more to reach the peripheral inputs
    settle;
    chk_pins;
    rd(SEL_A[2], 32'h0, 2'h0);
    final_report;
  end
endmodule // port_function_select_tb
